// >>> core/aoc_chk_if.sv
// carrier between the channel logic and its limit checker
// assumes one instance per channel, all on aclk
`timescale 1ns/1ps
interface aoc_chk_if;
  aoc_pkg::aoc_fmt_e fmt;
  logic [15:0]       value;
  logic [15:0]       upper;
  logic [15:0]       lower;
  logic              upper_en;
  logic              lower_en;
  logic              upper_err;
  logic              lower_err;

  modport ctl (output fmt, value, upper, lower, upper_en, lower_en,
               input upper_err, lower_err);
  modport chk (input fmt, value, upper, lower, upper_en, lower_en,
               output upper_err, lower_err);
endinterface

// >>> core/aoc_limit_chk.sv
// per-channel output value limit checker
// assumes synchronous active-low reset on aclk; errors are registered
`timescale 1ns/1ps
module aoc_limit_chk (
  input  wire logic aclk,    // block clock
  input  wire logic aresetn, // synchronous reset, active low
  aoc_chk_if.chk    chk      // value, limits and errors
);

  logic signed [16:0] val_s;
  logic signed [16:0] up_s;
  logic signed [16:0] lo_s;

  // bring the value into plain signed form so one comparison fits all formats
  always_comb
  begin
    case (chk.fmt)
      aoc_pkg::FMT_OFFSET_BIN: val_s = {1'b0, chk.value} - 17'sh08000;
      aoc_pkg::FMT_SIGN_MAG:   val_s = chk.value[15] ? -$signed({2'b00, chk.value[14:0]})
                                                     : $signed({2'b00, chk.value[14:0]});
      default:                 val_s = {chk.value[15], chk.value};
    endcase
    up_s = {chk.upper[15], chk.upper};
    lo_s = {chk.lower[15], chk.lower};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chk.upper_err <= 1'b0;
      chk.lower_err <= 1'b0;
    end
    else
    begin
      chk.upper_err <= chk.upper_en && (val_s > up_s);
      chk.lower_err <= chk.lower_en && (val_s < lo_s);
    end
  end

endmodule

// >>> core/aoc_pkg.sv
// shared constants for the analog output channel control block
// assumes a 32-bit AXI4-Lite register bus and a fixed count of four channels
package aoc_pkg;

  localparam int          NUM_CH        = 4;
  localparam int          AXI_AW        = 12;

  // global register byte offsets
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_STATUS    = 12'h004;
  localparam logic [11:0] OFF_MASK      = 12'h008;
  localparam logic [11:0] OFF_LIVE      = 12'h00C;
  // channel window: base + ch * stride + index * 4
  localparam logic [3:0]  CH_WIN        = 4'h1;
  localparam logic [2:0]  IDX_CFG       = 3'h0;
  localparam logic [2:0]  IDX_VALUE     = 3'h1;
  localparam logic [2:0]  IDX_UPPER     = 3'h2;
  localparam logic [2:0]  IDX_LOWER     = 3'h3;
  localparam logic [2:0]  IDX_FAULT     = 3'h4;
  localparam logic [2:0]  IDX_IDLE      = 3'h5;

  // control register fields
  localparam int          CTRL_SC_EN    = 0;
  localparam int          CTRL_FMT_LO   = 1;
  localparam int          CTRL_SW_PRIO  = 3;
  localparam logic        SC_EN_RST     = 1'b1;

  // status, mask and live register fields
  localparam int          ST_SHORT      = 0;
  localparam int          ST_UPPER_LO   = 4;
  localparam int          ST_LOWER_LO   = 8;
  localparam int          LV_COMM_ERR   = 0;
  localparam int          LV_COMM_IDLE  = 1;
  localparam int          LV_SHORT      = 2;

  // channel config fields
  localparam int          CFG_RANGE_LO  = 0;
  localparam int          CFG_UPPER_EN  = 3;
  localparam int          CFG_LOWER_EN  = 4;
  localparam int          CFG_FAULT_EN  = 5;
  localparam int          CFG_IDLE_EN   = 6;
  localparam int          CFG_W         = 7;

  typedef enum logic [1:0] {
    FMT_OFFSET_BIN,
    FMT_SIGN_MAG,
    FMT_TWOS,
    FMT_SCALED
  } aoc_fmt_e;

  typedef enum logic [2:0] {
    RNG_0_10V,
    RNG_0_5V,
    RNG_1_5V,
    RNG_0_20MA,
    RNG_4_20MA
  } aoc_range_e;

  localparam logic [2:0]  RANGE_RST     = 3'h0;
  localparam logic [2:0]  RANGE_MAX     = 3'h4;
  localparam logic [15:0] UPPER_RST     = 16'h03E8;
  localparam logic [15:0] LOWER_RST     = 16'h0000;
  // limit values that the limit registers refuse
  localparam logic [15:0] UPPER_BAD_A   = 16'h8000;
  localparam logic [15:0] UPPER_BAD_B   = 16'h8001;
  localparam logic [15:0] LOWER_BAD_A   = 16'h8000;
  localparam logic [15:0] LOWER_BAD_B   = 16'h7FFF;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// >>> core/aoc_top.sv
// analog output channel control: config, limit supervision and output selection
// assumes an AXI4-Lite master on aclk and pins from outside that need synchronising
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module aoc_top (
  input  wire logic        aclk,          // 20 MHz block clock
  input  wire logic        aresetn,       // synchronous reset, active low
  input  wire logic [11:0] s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write byte enables
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [11:0] s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  input  wire logic        comm_err,      // fieldbus communication error, async
  input  wire logic        comm_idle,     // fieldbus idle, async
  input  wire logic        short_det,     // output device short detected, async
  output logic [63:0]      aout_code,     // per-channel output codes, channel 0 lowest
  output logic [11:0]      aout_range,    // per-channel range selects
  output logic             irq            // level interrupt
);

  localparam int N = aoc_pkg::NUM_CH;

  // pin synchronisers
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic       err_s;
  logic       idle_s;
  logic       short_s;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end
    else
    begin
      pin_meta_reg <= {short_det, comm_idle, comm_err};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign err_s   = pin_sync_reg[0];
  assign idle_s  = pin_sync_reg[1];
  assign short_s = pin_sync_reg[2];

  // AXI4-Lite write path: address and data taken in either order
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic        wr_en;
  logic        wr_hit;
  logic [31:0] wmask;

  assign wr_en = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}},
                  {8{w_strb_reg[0]}}};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= 12'h000;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= aoc_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_en)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? aoc_pkg::RESP_OKAY : aoc_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // global registers
  logic              sc_en_reg;
  logic              sw_prio_reg;
  aoc_pkg::aoc_fmt_e fmt_reg;
  logic [15:0]       status_reg;
  logic [15:0]       mask_reg;
  logic [15:0]       events;
  logic [15:0]       live;
  logic [31:0]       ctrl_word;
  logic [31:0]       ctrl_new;
  logic              wr_ctrl;
  logic              wr_status;
  logic              wr_mask;
  logic              wr_win;
  logic [31:0]       status_clr;

  assign wr_ctrl    = wr_en && (aw_addr_reg == aoc_pkg::OFF_CTRL);
  assign wr_status  = wr_en && (aw_addr_reg == aoc_pkg::OFF_STATUS);
  assign wr_mask    = wr_en && (aw_addr_reg == aoc_pkg::OFF_MASK);
  assign wr_win     = (aw_addr_reg[11:8] == aoc_pkg::CH_WIN) && !aw_addr_reg[7]
                      && (aw_addr_reg[4:2] <= aoc_pkg::IDX_IDLE) && (aw_addr_reg[1:0] == 2'h0);
  assign wr_hit     = wr_win || (aw_addr_reg == aoc_pkg::OFF_CTRL)
                      || (aw_addr_reg == aoc_pkg::OFF_STATUS) || (aw_addr_reg == aoc_pkg::OFF_MASK)
                      || (aw_addr_reg == aoc_pkg::OFF_LIVE);
  assign ctrl_word  = {28'h0000000, sw_prio_reg, fmt_reg, sc_en_reg};
  assign ctrl_new   = merge(ctrl_word, w_data_reg, wmask);
  assign status_clr = wr_status ? (w_data_reg & wmask) : 32'h00000000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sc_en_reg   <= aoc_pkg::SC_EN_RST;
      fmt_reg     <= aoc_pkg::FMT_OFFSET_BIN;
      sw_prio_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      sc_en_reg   <= ctrl_new[aoc_pkg::CTRL_SC_EN];
      fmt_reg     <= aoc_pkg::aoc_fmt_e'(ctrl_new[aoc_pkg::CTRL_FMT_LO +: 2]);
      sw_prio_reg <= ctrl_new[aoc_pkg::CTRL_SW_PRIO];
    end
  end

  // sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_reg <= 16'h0000;
    else
      status_reg <= (status_reg & ~status_clr[15:0]) | events;
  end

  logic [31:0] mask_new;

  assign mask_new = merge({16'h0000, mask_reg}, w_data_reg, wmask);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask_reg <= 16'h0000;
    else if (wr_mask)
      mask_reg <= mask_new[15:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(status_reg & mask_reg);
  end

  // per-channel configuration, supervision and output selection
  localparam int CFG_W_T = aoc_pkg::CFG_W;
  logic [CFG_W_T-1:0] cfg_q [N];
  logic [15:0]        val_q [N];
  logic [15:0]        up_q  [N];
  logic [15:0]        lo_q  [N];
  logic [15:0]        flt_q [N];
  logic [15:0]        idl_q [N];
  logic [N-1:0]       up_err;
  logic [N-1:0]       lo_err;

  genvar ch;
  generate
    for (ch = 0; ch < N; ch++)
    begin : g_ch
      aoc_chk_if   chk_if ();
      logic        sel;
      logic [31:0] nw;
      logic [31:0] cfg_new;
      logic [15:0] nw16;

      assign sel     = wr_en && wr_win && (aw_addr_reg[6:5] == 2'(ch));
      assign nw      = w_data_reg;
      assign cfg_new = merge({25'h0, cfg_q[ch]}, nw, wmask);
      assign nw16    = nw[15:0] & wmask[15:0];

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          cfg_q[ch] <= {4'h0, aoc_pkg::RANGE_RST};
          val_q[ch] <= 16'h0000;
          up_q[ch]  <= aoc_pkg::UPPER_RST;
          lo_q[ch]  <= aoc_pkg::LOWER_RST;
          flt_q[ch] <= 16'h0000;
          idl_q[ch] <= 16'h0000;
        end
        else if (sel)
        begin
          case (aw_addr_reg[4:2])
            aoc_pkg::IDX_CFG:
              if (cfg_new[2:0] <= aoc_pkg::RANGE_MAX)
                cfg_q[ch] <= cfg_new[CFG_W_T-1:0];
            aoc_pkg::IDX_VALUE: val_q[ch] <= (val_q[ch] & ~wmask[15:0]) | nw16;
            aoc_pkg::IDX_UPPER:
              if (nw[15:0] != aoc_pkg::UPPER_BAD_A && nw[15:0] != aoc_pkg::UPPER_BAD_B)
                up_q[ch] <= nw[15:0];
            aoc_pkg::IDX_LOWER:
              if (nw[15:0] != aoc_pkg::LOWER_BAD_A && nw[15:0] != aoc_pkg::LOWER_BAD_B)
                lo_q[ch] <= nw[15:0];
            aoc_pkg::IDX_FAULT: flt_q[ch] <= (flt_q[ch] & ~wmask[15:0]) | nw16;
            aoc_pkg::IDX_IDLE:  idl_q[ch] <= (idl_q[ch] & ~wmask[15:0]) | nw16;
            default:            cfg_q[ch] <= cfg_q[ch];
          endcase
        end
      end

      assign chk_if.fmt      = fmt_reg;
      assign chk_if.value    = val_q[ch];
      assign chk_if.upper    = up_q[ch];
      assign chk_if.lower    = lo_q[ch];
      assign chk_if.upper_en = cfg_q[ch][aoc_pkg::CFG_UPPER_EN];
      assign chk_if.lower_en = cfg_q[ch][aoc_pkg::CFG_LOWER_EN];
      assign up_err[ch]      = chk_if.upper_err;
      assign lo_err[ch]      = chk_if.lower_err;

      aoc_limit_chk u_chk (
        .aclk    (aclk),
        .aresetn (aresetn),
        .chk     (chk_if.chk)
      );

      // without software priority, comm loss simply freezes the output
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          aout_code[ch*16 +: 16] <= 16'h0000;
        else if (err_s)
        begin
          if (sw_prio_reg && cfg_q[ch][aoc_pkg::CFG_FAULT_EN])
            aout_code[ch*16 +: 16] <= flt_q[ch];
        end
        else if (idle_s)
        begin
          if (sw_prio_reg && cfg_q[ch][aoc_pkg::CFG_IDLE_EN])
            aout_code[ch*16 +: 16] <= idl_q[ch];
        end
        else
          aout_code[ch*16 +: 16] <= val_q[ch];
      end

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          aout_range[ch*3 +: 3] <= aoc_pkg::RANGE_RST;
        else
          aout_range[ch*3 +: 3] <= cfg_q[ch][2:0];
      end

      fault_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
        err_s && sw_prio_reg && cfg_q[ch][aoc_pkg::CFG_FAULT_EN]
        |=> aout_code[ch*16 +: 16] == $past(flt_q[ch]))
        else $error("fault value not driven");
      idle_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !err_s && idle_s && sw_prio_reg && cfg_q[ch][aoc_pkg::CFG_IDLE_EN]
        |=> aout_code[ch*16 +: 16] == $past(idl_q[ch]))
        else $error("idle value not driven");
      hold_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (err_s || idle_s) && !sw_prio_reg |=> $stable(aout_code[ch*16 +: 16]))
        else $error("output moved without software priority");
      range_ok_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_q[ch][2:0] <= aoc_pkg::RANGE_MAX)
        else $error("range select out of set");
      upper_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
        up_q[ch] != aoc_pkg::UPPER_BAD_A && up_q[ch] != aoc_pkg::UPPER_BAD_B)
        else $error("upper limit outside accepted span");
      lower_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
        lo_q[ch] != aoc_pkg::LOWER_BAD_A && lo_q[ch] != aoc_pkg::LOWER_BAD_B)
        else $error("lower limit outside accepted span");
    end
  endgenerate

  always_comb
  begin
    events = 16'h0000;
    events[aoc_pkg::ST_SHORT] = sc_en_reg && short_s;
    events[aoc_pkg::ST_UPPER_LO +: N] = up_err;
    events[aoc_pkg::ST_LOWER_LO +: N] = lo_err;
    live = events;
    live[aoc_pkg::LV_COMM_ERR]  = err_s;
    live[aoc_pkg::LV_COMM_IDLE] = idle_s;
    live[aoc_pkg::LV_SHORT]     = short_s;
  end

  // AXI4-Lite read path, one read under way at a time
  logic [31:0] rd_next;
  logic [1:0]  rresp_next;
  logic [1:0]  rch;

  assign rch = s_axi_araddr[6:5];

  always_comb
  begin
    rd_next    = 32'h00000000;
    rresp_next = aoc_pkg::RESP_OKAY;
    if (s_axi_araddr == aoc_pkg::OFF_CTRL)
      rd_next = ctrl_word;
    else if (s_axi_araddr == aoc_pkg::OFF_STATUS)
      rd_next = {16'h0000, status_reg};
    else if (s_axi_araddr == aoc_pkg::OFF_MASK)
      rd_next = {16'h0000, mask_reg};
    else if (s_axi_araddr == aoc_pkg::OFF_LIVE)
      rd_next = {16'h0000, live};
    else if (s_axi_araddr[11:8] == aoc_pkg::CH_WIN && !s_axi_araddr[7]
             && s_axi_araddr[1:0] == 2'h0)
    begin
      case (s_axi_araddr[4:2])
        aoc_pkg::IDX_CFG:   rd_next = {25'h0, cfg_q[rch]};
        aoc_pkg::IDX_VALUE: rd_next = {16'h0000, val_q[rch]};
        aoc_pkg::IDX_UPPER: rd_next = {16'h0000, up_q[rch]};
        aoc_pkg::IDX_LOWER: rd_next = {16'h0000, lo_q[rch]};
        aoc_pkg::IDX_FAULT: rd_next = {16'h0000, flt_q[rch]};
        aoc_pkg::IDX_IDLE:  rd_next = {16'h0000, idl_q[rch]};
        default:            rresp_next = aoc_pkg::RESP_SLVERR;
      endcase
    end
    else
      rresp_next = aoc_pkg::RESP_SLVERR;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= aoc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_next;
      s_axi_rresp   <= rresp_next;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  short_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sc_en_reg && short_s |=> status_reg[aoc_pkg::ST_SHORT])
    else $error("short not flagged");
  short_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(status_reg[aoc_pkg::ST_SHORT]) |-> $past(sc_en_reg) && $past(short_s))
    else $error("short flagged while detection off");
  fmt_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctrl && w_strb_reg[0] |=> fmt_reg == $past(w_data_reg[2:1]))
    else $error("format write not taken");
  limit_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    |(up_err | lo_err) |=> (status_reg[aoc_pkg::ST_UPPER_LO +: N] & $past(up_err)) == $past(up_err)
    && (status_reg[aoc_pkg::ST_LOWER_LO +: N] & $past(lo_err)) == $past(lo_err))
    else $error("limit error not latched");
  flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    status_reg[aoc_pkg::ST_SHORT] && !status_clr[aoc_pkg::ST_SHORT]
    |=> status_reg[aoc_pkg::ST_SHORT])
    else $error("flag dropped without clear");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    |(status_reg & mask_reg) |=> irq)
    else $error("interrupt not raised");

endmodule

// >>> testbench/aoc_plc_model.sv
// fieldbus master stand-in: drives the link error and idle levels
// assumes the bench picks the mode; levels change only after aclk edges
`timescale 1ns/1ps
module aoc_plc_model (
  input  wire logic       aclk,     // block clock
  input  wire logic [1:0] mode,     // 0 running, 1 link fault, 2 idle
  output logic            comm_err, // link error level
  output logic            comm_idle // idle level
);
  always_ff @(posedge aclk)
  begin
    comm_err  <= (mode == 2'h1);
    comm_idle <= (mode == 2'h2);
  end
endmodule

// >>> testbench/tb_aoc_top.sv
// self-checking bench for the analog output channel control block
// assumes the plc model drives the link pins; registers reached over axi4-lite
`timescale 1ns/1ps
module tb_aoc_top;
  logic        aclk = 1'b0, aresetn = 1'b0, short_det = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000, aout_range;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic        awready, wready, bvalid, arready, rvalid, irq, comm_err, comm_idle;
  logic [1:0]  bresp, rresp, r, mode = 2'h0;
  logic [63:0] aout_code;
  logic [15:0] lf = 16'h003F, v;
  int          n_errors = 0, comparisons = 0, cyc = 0, s, rng[4] = '{0, 0, 0, 0};

  aoc_top aoc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .comm_err(comm_err),
    .comm_idle(comm_idle), .short_det(short_det), .aout_code(aout_code),
    .aout_range(aout_range), .irq(irq));
  aoc_plc_model aoc_plc_model_inst (.aclk(aclk), .mode(mode), .comm_err(comm_err),
    .comm_idle(comm_idle));

  always #25 aclk = ~aclk;

  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // signed reading of a code in each data format
  function automatic int sv(input logic [15:0] x, input int f);
    if (f == 0)
      return int'(x) - 32768;
    if (f == 1)
      return x[15] ? -int'(x[14:0]) : int'(x[14:0]);
    return int'($signed(x));
  endfunction
  function automatic logic [11:0] ca(input int c, input logic [2:0] i);
    return {aoc_pkg::CH_WIN, 1'b0, 2'(c), i, 2'b00};
  endfunction

  task automatic results();
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dat);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= dat;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!bvalid)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!rvalid)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      results();
    end
  end

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(aoc_pkg::OFF_CTRL);
    chk(d, 32'h1);
    rd(ca(2, aoc_pkg::IDX_UPPER));
    chk(d, 32'h3E8);
    rd(aoc_pkg::OFF_LIVE);
    chk(d[11:4], 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr(ca(i % 4, aoc_pkg::IDX_CFG), 32'(i));
      if (i < 5)
        rng[i % 4] = i;
      @(posedge aclk);
      chk(aout_range, {3'(rng[3]), 3'(rng[2]), 3'(rng[1]), 3'(rng[0])});
    end
    short_det <= 1'b1;
    wr(aoc_pkg::OFF_MASK, 32'h1);
    repeat (4) @(posedge aclk);
    chk(irq, 1'b1);
    wr(aoc_pkg::OFF_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    wr(aoc_pkg::OFF_CTRL, 32'h0);
    wr(aoc_pkg::OFF_STATUS, 32'h1);
    repeat (4) @(posedge aclk);
    rd(aoc_pkg::OFF_STATUS);
    chk(d, 32'h0);
    short_det <= 1'b0;
    // lower set value of -500, both checks on, every format in turn
    wr(ca(0, aoc_pkg::IDX_LOWER), 32'hFE0C);
    wr(ca(0, aoc_pkg::IDX_CFG), 32'h18);
    for (int i = 0; i < 16; i++)
    begin
      lf = nx(lf);
      v = (lf == 16'h8000) ? 16'h8001 : lf;
      wr(aoc_pkg::OFF_CTRL, {29'h0, 2'(i % 4), 1'b1});
      wr(ca(0, aoc_pkg::IDX_VALUE), {16'h0, v});
      repeat (4) @(posedge aclk);
      rd(aoc_pkg::OFF_LIVE);
      s = sv(v, i % 4);
      chk(d[8], s < -500);
      chk(d[4], s > 1000);
    end
    // start from a clean flag so the sticky check below can really fail
    wr(ca(0, aoc_pkg::IDX_VALUE), 32'h0);
    repeat (4) @(posedge aclk);
    wr(aoc_pkg::OFF_STATUS, 32'hFFF);
    rd(aoc_pkg::OFF_STATUS);
    chk(d[4], 1'b0);
    wr(ca(0, aoc_pkg::IDX_VALUE), 32'h07D0);
    repeat (4) @(posedge aclk);
    wr(ca(0, aoc_pkg::IDX_VALUE), 32'h0);
    repeat (4) @(posedge aclk);
    rd(aoc_pkg::OFF_STATUS);
    chk(d[4], 1'b1);
    wr(aoc_pkg::OFF_STATUS, 32'hFFF);
    rd(aoc_pkg::OFF_STATUS);
    chk(d[4], 1'b0);
    wr(ca(0, aoc_pkg::IDX_UPPER), 32'h8001);
    rd(ca(0, aoc_pkg::IDX_UPPER));
    chk(d, 32'h3E8);
    wr(ca(0, aoc_pkg::IDX_LOWER), 32'h7FFF);
    rd(ca(0, aoc_pkg::IDX_LOWER));
    chk(d, 32'hFE0C);
    // software priority, fault 5.25 V and idle 0.75 V on channel 0 only
    wr(aoc_pkg::OFF_CTRL, 32'h9);
    wr(ca(0, aoc_pkg::IDX_CFG), 32'h60);
    wr(ca(0, aoc_pkg::IDX_FAULT), 32'd525);
    wr(ca(0, aoc_pkg::IDX_IDLE), 32'd75);
    wr(ca(1, aoc_pkg::IDX_VALUE), 32'h55);
    wr(ca(0, aoc_pkg::IDX_VALUE), 32'h1234);
    wr(ca(3, aoc_pkg::IDX_VALUE), {16'h0, lf});
    repeat (2) @(posedge aclk);
    chk(aout_code[31:0], 32'h0055_1234);
    chk(aout_code[63:32], {lf, 16'h0});
    mode <= 2'h1;
    repeat (6) @(posedge aclk);
    chk(aout_code[31:0], 32'h0055_020D);
    mode <= 2'h2;
    repeat (6) @(posedge aclk);
    chk(aout_code[31:0], 32'h0055_004B);
    mode <= 2'h0;
    wr(aoc_pkg::OFF_CTRL, 32'h1);
    repeat (6) @(posedge aclk);
    mode <= 2'h1;
    repeat (6) @(posedge aclk);
    chk(aout_code[31:0], 32'h0055_1234);
    mode <= 2'h0;
    wr(12'h118, 32'hF);
    chk(r, aoc_pkg::RESP_SLVERR);
    rd(12'h118);
    chk(r, aoc_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    results();
  end
endmodule
